// [hdl/uvep_ctrl.sv]
// host controller that reads and programs the uv eprom through its pins
`timescale 1ns/1ns

module uvep_ctrl
   import uvep_pkg::*;
#(
   parameter int PULSE_CYC = PULSE_CYC_DEF, // program pulse length
   parameter int NUM_LOOPS = LOOPS_DEF      // full-array passes
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // image load port
   input wire logic i_load_we,
   input wire logic [ADDR_W-1:0] i_load_addr,
   input wire logic [DATA_W-1:0] i_load_data,
   // read request port
   input wire logic i_read_req,
   input wire logic [ADDR_W-1:0] i_read_addr,
   output logic o_read_valid,
   output logic [DATA_W-1:0] o_read_data,
   // program request port
   input wire logic i_prog_start,
   output logic o_prog_done,
   output logic o_busy,
   // device pins
   output logic [ADDR_W-1:0] o_word_addr,
   output logic o_select_high,
   output logic o_program_enable_high,
   output logic o_program_pulse,
   output logic [DATA_W-1:0] o_data_out,
   output logic o_data_oe,
   input wire logic [DATA_W-1:0] i_data_in
);

   // refuse settings the counters cannot hold
   if (PULSE_CYC < 1 || PULSE_CYC >= (1 << TMR_W)) begin : g_chk_pulse
      $error("pulse length does not fit the timer");
   end
   if (NUM_LOOPS < 1 || NUM_LOOPS >= (1 << TMR_W)) begin : g_chk_loops
      $error("loop count does not fit the loop counter");
   end

   localparam logic [TMR_W-1:0] LAST_LOOP = TMR_W'(NUM_LOOPS - 1);

   logic rst_meta_r; // reset release, first stage
   logic rst_n_r;    // reset used by the whole design
   logic [DATA_W-1:0] data_meta_r; // data pins, first stage only
   logic [DATA_W-1:0] data_sync_r; // data pins, safe to read
   logic [DATA_W-1:0] image_r [NUM_WORDS]; // bytes to be burned
   uvep_state_e state_r;   // current state
   uvep_state_e state_nxt; // next state
   logic tmr_load;            // restart timer on a state change
   logic [TMR_W-1:0] tmr_val; // cycles minus one for the new state
   logic tmr_done;            // timer reached zero
   logic [ADDR_W-1:0] word_r; // word being programmed
   logic [TMR_W-1:0] loop_r;  // completed loops
   logic last_word;           // final word of final loop
   logic [ADDR_W-1:0] next_word; // following address, wraps to zero

   assign last_word = (word_r == LAST_WORD) && (loop_r == LAST_LOOP);
   assign next_word = word_r + 1'b1;

   // two-stage reset release; assertion is still immediate
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // pins are asynchronous to us, so two flops before use
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         data_meta_r <= '0;
         data_sync_r <= '0;
      end else begin
         data_meta_r <= i_data_in;
         data_sync_r <= data_meta_r;
      end
   end

   // image store; loads are taken only while idle so a burn sees one image
   always_ff @(posedge i_clk) begin
      if (i_load_we && state_r == S_IDLE) begin
         image_r[i_load_addr] <= i_load_data;
      end
   end

   // shared state timer
   uvep_timer #(
      .W(TMR_W)
   ) u_timer (
      .i_clk(i_clk),
      .i_rst_n(rst_n_r),
      .i_load(tmr_load),
      .i_value(tmr_val),
      .o_done(tmr_done)
   );

   // next state and timer reload; each state lasts its full count
   always_comb begin
      state_nxt = state_r;
      tmr_load = 1'b0;
      tmr_val = '0;
      case (state_r)
         S_IDLE: begin
            // program request has priority over a read in the same cycle
            if (i_prog_start) begin
               state_nxt = S_PG_ENTER;
               tmr_load = 1'b1;
               tmr_val = TMR_W'(PE_SU_CYC - 1);
            end else if (i_read_req) begin
               state_nxt = S_RD_WAIT;
               tmr_load = 1'b1;
               tmr_val = TMR_W'(RD_CYC - 1);
            end
         end
         S_RD_WAIT: begin
            if (tmr_done) begin
               state_nxt = S_RD_DONE;
            end
         end
         S_RD_DONE: begin
            state_nxt = S_IDLE;
         end
         S_PG_ENTER: begin
            if (tmr_done) begin
               state_nxt = S_PG_SETUP;
               tmr_load = 1'b1;
               tmr_val = TMR_W'(ADDR_SU_CYC - 1);
            end
         end
         S_PG_SETUP: begin
            if (tmr_done) begin
               state_nxt = S_PG_PULSE;
               tmr_load = 1'b1;
               tmr_val = TMR_W'(PULSE_CYC - 1);
            end
         end
         S_PG_PULSE: begin
            if (tmr_done) begin
               state_nxt = S_PG_RECOV;
               tmr_load = 1'b1;
               tmr_val = TMR_W'(REC_CYC - 1);
            end
         end
         S_PG_RECOV: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (last_word) begin
                  state_nxt = S_PG_EXIT;
                  tmr_val = TMR_W'(PE_HOLD_CYC - 1);
               end else begin
                  state_nxt = S_PG_SETUP;
                  tmr_val = TMR_W'(ADDR_SU_CYC - 1);
               end
            end
         end
         S_PG_EXIT: begin
            if (tmr_done) begin
               state_nxt = S_PG_SETTLE;
               tmr_load = 1'b1;
               tmr_val = TMR_W'(INVALID_CYC - 1);
            end
         end
         S_PG_SETTLE: begin
            if (tmr_done) begin
               state_nxt = S_IDLE;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // word and loop counters, address and data pins move together; a read moves the address alone
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         word_r <= '0;
         loop_r <= '0;
         o_word_addr <= '0;
         o_data_out <= '0;
      end else if (state_r == S_IDLE && state_nxt == S_PG_ENTER) begin
         word_r <= '0;
         loop_r <= '0;
         o_word_addr <= '0;
         o_data_out <= image_r[0];
      end else if (state_r == S_IDLE && state_nxt == S_RD_WAIT) begin
         o_word_addr <= i_read_addr;
      end else if (state_r == S_PG_RECOV && state_nxt == S_PG_SETUP) begin
         // new address only after the recovery wait
         word_r <= next_word;
         o_word_addr <= next_word;
         o_data_out <= image_r[next_word];
         if (word_r == LAST_WORD) begin
            loop_r <= loop_r + 1'b1;
         end
      end
   end

   // enable level and data drive; data is released with the drop to
   // logic low, and the address holds through the settle wait
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_program_enable_high <= 1'b0;
         o_select_high <= 1'b1;
         o_data_oe <= 1'b0;
      end else begin
         case (state_nxt)
            S_PG_ENTER, S_PG_SETUP, S_PG_PULSE, S_PG_RECOV,
            S_PG_EXIT: begin
               o_program_enable_high <= 1'b1;
               o_select_high <= 1'b1;
               o_data_oe <= 1'b1;
            end
            S_RD_WAIT, S_RD_DONE, S_PG_SETTLE: begin
               o_program_enable_high <= 1'b0;
               o_select_high <= 1'b0;
               o_data_oe <= 1'b0;
            end
            default: begin
               o_program_enable_high <= 1'b0;
               o_select_high <= 1'b1; // deselected, pins float
               o_data_oe <= 1'b0;
            end
         endcase
      end
   end

   // program pulse only in its own state, never while reading
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_program_pulse <= 1'b0;
      end else begin
         o_program_pulse <= (state_nxt == S_PG_PULSE);
      end
   end

   // user status and read answer
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_busy <= 1'b0;
         o_prog_done <= 1'b0;
         o_read_valid <= 1'b0;
         o_read_data <= '0;
      end else begin
         o_busy <= (state_nxt != S_IDLE);
         o_prog_done <= (state_r == S_PG_SETTLE) && tmr_done;
         o_read_valid <= (state_r == S_RD_WAIT) && tmr_done;
         if (state_r == S_RD_WAIT && tmr_done) begin
            o_read_data <= data_sync_r;
         end
      end
   end

   // checking helpers: pulse length, setup age, pulse total
   logic [TMR_W-1:0] pulse_len_r; // cycles the pulse has been high
   logic [TMR_W-1:0] stable_r;    // cycles since address or data moved
   logic [31:0] pulses_r;         // pulses in the current burn
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pulse_len_r <= '0;
         stable_r <= '0;
         pulses_r <= '0;
      end else begin
         pulse_len_r <= o_program_pulse ? pulse_len_r + 1'b1 : '0;
         if (o_word_addr != $past(o_word_addr) ||
             o_data_out != $past(o_data_out) || !o_data_oe) begin
            stable_r <= '0;
         end else if (stable_r != '1) begin
            stable_r <= stable_r + 1'b1;
         end
         if (state_r == S_IDLE) begin
            pulses_r <= '0;
         end else if ($rose(o_program_pulse)) begin
            pulses_r <= pulses_r + 1'b1;
         end
      end
   end

   // all checks run on the one clock and sleep through reset
   default clocking cb_chk @(posedge i_clk); endclocking
   default disable iff (!rst_n_r);

   a_read_no_pulse: assert property (
      o_program_pulse |-> o_program_enable_high && o_data_oe)
      else $error("program pulse outside program mode");

   a_no_contention: assert property (
      !o_select_high |-> !o_data_oe)
      else $error("data driven while device selected");

   a_pulse_width: assert property (
      $fell(o_program_pulse) |-> pulse_len_r == TMR_W'(PULSE_CYC))
      else $error("program pulse length wrong");

   a_setup_before: assert property (
      $rose(o_program_pulse) |-> stable_r >= TMR_W'(ADDR_SU_CYC - 1))
      else $error("address or data not set up before pulse");

   a_pulse_recover: assert property (
      $fell(o_program_pulse) |-> $stable(o_word_addr)[*8] ##1 !o_program_pulse)
      else $error("address moved too soon after pulse");

   a_exit_order: assert property (
      $fell(o_program_enable_high) |-> $past(!o_program_pulse, 2) && !o_data_oe)
      else $error("program enable dropped with pulse or data active");

   a_enable_held: assert property (
      state_r inside {S_PG_SETUP, S_PG_PULSE, S_PG_RECOV} |->
      o_program_enable_high)
      else $error("program enable lost during sequence");

   a_settle_wait: assert property (
      $fell(o_program_enable_high) |-> !o_prog_done[*8] ##1 o_busy)
      else $error("burn finished inside invalid window");

   a_start_zero: assert property (
      $rose(o_program_enable_high) |-> o_word_addr == '0)
      else $error("burn did not start at address zero");

   a_loop_total: assert property (
      o_prog_done |-> pulses_r == 32'(NUM_LOOPS * NUM_WORDS))
      else $error("wrong number of program pulses");

endmodule : uvep_ctrl

// [hdl/uvep_common.sv]
// constants package and cycle timer for the eprom programmer/reader
package uvep_pkg;

   // system clock period
   localparam int T_CLK_NS = 100;

   // array shape
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int NUM_WORDS = 1024;
   localparam logic [9:0] LAST_WORD = 10'h3FF;

   // timing figures as printed, in their own units
   localparam int T_READ_ACC_NS = 450;       // access time from address
   localparam int T_PE_SETUP_NS = 10000;     // program enable setup
   localparam int T_ADDR_SETUP_NS = 10000;   // address and data setup
   localparam int T_RECOVER_NS = 1000;       // wait after pulse end
   localparam int T_PE_HOLD_NS = 500;        // program enable hold
   localparam int T_EXIT_INVALID_NS = 10000; // outputs invalid after exit
   localparam int T_PULSE_MAX_NS = 1000000;  // longest program pulse
   localparam int T_LOOP_TOTAL_NS = 100000000; // pulses per word, summed

   // least time rounded up to whole cycles, never below one
   function automatic int cyc_ceil(input int ns);
      int c;
      c = (ns + T_CLK_NS - 1) / T_CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_ceil

   // input synchroniser depth
   localparam int SYNC_CYC = 2;

   // derived cycle counts
   localparam int RD_CYC = cyc_ceil(T_READ_ACC_NS) + SYNC_CYC;
   localparam int PE_SU_CYC = cyc_ceil(T_PE_SETUP_NS);
   localparam int ADDR_SU_CYC = cyc_ceil(T_ADDR_SETUP_NS);
   localparam int REC_CYC = cyc_ceil(T_RECOVER_NS);
   localparam int PE_HOLD_CYC = cyc_ceil(T_PE_HOLD_NS);
   localparam int INVALID_CYC = cyc_ceil(T_EXIT_INVALID_NS);
   localparam int PULSE_CYC_DEF = T_PULSE_MAX_NS / T_CLK_NS;
   localparam int LOOPS_DEF =
      (T_LOOP_TOTAL_NS + T_PULSE_MAX_NS - 1) / T_PULSE_MAX_NS;

   // timer width
   localparam int TMR_W = 16;

   // controller states, gray along the programming path except recovery back to setup and settle back to idle
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_RD_WAIT = 4'h1,
      S_RD_DONE = 4'h3,
      S_PG_ENTER = 4'h2,
      S_PG_SETUP = 4'h6,
      S_PG_PULSE = 4'h7,
      S_PG_RECOV = 4'h5,
      S_PG_EXIT = 4'h4,
      S_PG_SETTLE = 4'hC
   } uvep_state_e;

endpackage : uvep_pkg

`timescale 1ns/1ns

// down counter: load a value, done while it stands at zero
module uvep_timer #(
   parameter int W = 16
) (
   // clock and synchronised reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // control
   input wire logic i_load,
   input wire logic [W-1:0] i_value,
   // status
   output logic o_done
);

   logic [W-1:0] cnt_r; // remaining cycles

   // count down, reload wins over counting
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
      end else if (i_load) begin
         cnt_r <= i_value;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign o_done = (cnt_r == '0);

endmodule : uvep_timer

// [test/uvep_dev_model.sv]
// pin-level behavioural model of the uv eprom
`timescale 1ns/1ns
module uvep_dev_model
   import uvep_pkg::*;
#(
   parameter int MIN_PULSE_NS = 100000, // shortest legal pulse
   parameter int MAX_PULSE_NS = 1000000 // longest legal pulse
) (
   // pins from the controller
   input wire logic [ADDR_W-1:0] i_word_addr,
   input wire logic i_select_high,
   input wire logic i_program_enable_high,
   input wire logic i_program_pulse,
   input wire logic [DATA_W-1:0] i_data,
   input wire logic i_host_drive,
   // device drive onto the data lines
   output logic [DATA_W-1:0] o_data,
   output logic o_drive,
   // bookkeeping read by the bench
   output int o_faults,
   output int o_pulses
);
   logic [DATA_W-1:0] mem [NUM_WORDS]; // cell array
   logic [ADDR_W-1:0] next_addr = '0; // word the next pulse must hit
   logic tick = 1'b0; // free toggle feeding the junk pattern
   logic inval = 1'b0; // outputs unsettled after leaving program mode
   logic pe_prev = 1'b0; // last seen program enable level
   logic pulse_on = 1'b0; // a real pulse is in progress
   time t_addr = 0, t_data = 0, t_rise = 0, t_fall = 0;

   // erased cells read high
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      o_faults = 0;
      o_pulses = 0;
   end

   always #50 tick = ~tick;

   task automatic fault(input string what);
      o_faults++;
      $display("ERROR %s expected legal seen violation", what);
   endtask : fault

   // select low drives the word; program level or high floats
   assign o_drive = !i_select_high && !i_program_enable_high;
   // junk while unsettled, since a reader must not rely on it
   assign o_data = inval ? ({8{tick}} ^ i_word_addr[7:0]) :
      mem[i_word_addr];

   // only a true fall from program level opens the junk window
   always @(i_program_enable_high) begin
      if (i_program_enable_high === 1'b1) t_data = $time;
      if (pe_prev === 1'b1 && i_program_enable_high === 1'b0) begin
         pe_prev = 1'b0;
         if (pulse_on) fault("pulse_at_exit");
         inval = 1'b1;
         #10000 inval = 1'b0;
      end
      pe_prev = i_program_enable_high;
   end

   // data setup is timed from the last data change
   always @(i_data) begin
      if (i_program_enable_high === 1'b1) t_data = $time;
      if (pulse_on) fault("data_hold");
   end

   // address moves: recovery, release and hold checks
   always @(i_word_addr) begin
      if (i_program_enable_high && ($time - t_fall < 1000))
         fault("recovery");
      if (!i_program_enable_high && i_host_drive)
         fault("data_not_released");
      if (pulse_on) fault("addr_hold");
      t_addr = $time;
   end

   // pulse start: mode, setup and address order
   always @(posedge i_program_pulse) begin
      o_pulses++;
      pulse_on = 1'b1;
      if (i_program_enable_high !== 1'b1) fault("pulse_mode");
      if ($time - t_addr < 10000 || $time - t_data < 10000)
         fault("setup");
      if (i_word_addr !== next_addr) fault("address_order");
      next_addr = i_word_addr + 1'b1;
      t_rise = $time;
   end

   // pulse end: width check and charge deposit, ones to zeros only
   always @(negedge i_program_pulse) begin
      if (pulse_on) begin
         if ($time - t_rise < MIN_PULSE_NS || $time - t_rise > MAX_PULSE_NS)
            fault("pulse_width");
         mem[i_word_addr] = mem[i_word_addr] & i_data;
         t_fall = $time;
         pulse_on = 1'b0;
      end
   end
endmodule : uvep_dev_model

// [test/tb_uvep_ctrl.sv]
// self-checking bench for the eprom host controller
`timescale 1ns/1ns
module tb_uvep_ctrl;
   import uvep_pkg::*;
   localparam int PCYC = 3; // shortened pulse, keeps the run brief
   localparam int NLOOP = 1; // one pass, each pass costs 116k cycles

   // controller inputs
   logic i_clk = 1'b0, i_reset_n = 1'b0;
   logic i_load_we = 1'b0, i_read_req = 1'b0, i_prog_start = 1'b0;
   logic [ADDR_W-1:0] i_load_addr = '0, i_read_addr = '0;
   logic [DATA_W-1:0] i_load_data = '0;
   // controller outputs
   logic o_read_valid, o_prog_done, o_busy, o_select_high;
   logic o_program_enable_high, o_program_pulse, o_data_oe;
   logic [DATA_W-1:0] o_read_data, o_data_out;
   logic [ADDR_W-1:0] o_word_addr;
   // resolved data lines; undriven lines flip every cycle
   logic [DATA_W-1:0] dev_data, bus, last_bus = '0;
   logic dev_drive;
   int faults, pulses, miscompares = 0, samples_checked = 0;

   assign bus = o_data_oe ? o_data_out : (dev_drive ? dev_data : ~last_bus);
   always @(posedge i_clk) last_bus <= bus;
   always #50 i_clk = ~i_clk;

   uvep_ctrl #(.PULSE_CYC(PCYC), .NUM_LOOPS(NLOOP)) u_uvep_ctrl (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_load_we(i_load_we),
      .i_load_addr(i_load_addr), .i_load_data(i_load_data),
      .i_read_req(i_read_req), .i_read_addr(i_read_addr),
      .o_read_valid(o_read_valid), .o_read_data(o_read_data),
      .i_prog_start(i_prog_start), .o_prog_done(o_prog_done),
      .o_busy(o_busy), .o_word_addr(o_word_addr),
      .o_select_high(o_select_high),
      .o_program_enable_high(o_program_enable_high),
      .o_program_pulse(o_program_pulse), .o_data_out(o_data_out),
      .o_data_oe(o_data_oe), .i_data_in(bus));

   uvep_dev_model #(.MIN_PULSE_NS(PCYC * T_CLK_NS)) u_uvep_dev_model (
      .i_word_addr(o_word_addr), .i_select_high(o_select_high),
      .i_program_enable_high(o_program_enable_high),
      .i_program_pulse(o_program_pulse), .i_data(bus),
      .i_host_drive(o_data_oe), .o_data(dev_data), .o_drive(dev_drive),
      .o_faults(faults), .o_pulses(pulses));

   // both sides driving the lines at once is a fight
   always @(negedge i_clk)
      if (o_data_oe === 1'b1 && dev_drive === 1'b1) begin
      miscompares++;
      $display("ERROR bus_contention expected 0 seen 1");
   end

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // image byte, mixes high and low address bits
   function automatic logic [7:0] img(input logic [9:0] a);
      return {a[1:0], a[9:4]} ^ 8'hA5;
   endfunction : img

   // one read; valid comes seven cycles after the taking edge, seen at the eighth falling edge
   task automatic do_read(input logic [9:0] a, input logic [7:0] exp);
      int n;
      @(posedge i_clk) i_read_req <= 1'b1;
      i_read_addr <= a;
      @(posedge i_clk) i_read_req <= 1'b0;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_read_valid !== 1'b1 && n < 20);
      chk("read_latency", 16'h0008, n[15:0]);
      chk("read_addr_pins", {6'h00, a}, {6'h00, o_word_addr});
      chk("read_data", {8'h00, exp}, {8'h00, o_read_data});
   endtask : do_read

   // idle pin levels straight after reset
   task automatic test_reset();
      @(negedge i_clk);
      chk("idle_pins", 16'h0800, {o_busy, o_program_pulse, o_data_oe,
          o_program_enable_high, o_select_high, 1'b0, o_word_addr});
      $display("test reset done");
   endtask : test_reset

   // an erased part reads all ones at both end addresses and at 10'h001 and 10'h200
   task automatic test_erased();
      do_read(10'h000, 8'hFF);
      do_read(10'h001, 8'hFF);
      do_read(10'h200, 8'hFF);
      do_read(10'h3FF, 8'hFF);
      $display("test erased done");
   endtask : test_erased

   // full burn with a read refused on the way, then readback
   task automatic test_burn();
      int n, busy_low, stray;
      for (int a = 0; a < NUM_WORDS; a++) begin
         @(posedge i_clk) i_load_we <= 1'b1;
         i_load_addr <= a[9:0];
         i_load_data <= img(a[9:0]);
      end
      @(posedge i_clk) i_load_we <= 1'b0;
      // a pre-cleared nibble must stay cleared
      u_uvep_dev_model.mem[5] = 8'h0F;
      @(posedge i_clk) i_prog_start <= 1'b1;
      @(posedge i_clk) i_prog_start <= 1'b0;
      n = 0;
      busy_low = 0;
      stray = 0;
      do begin
         @(posedge i_clk) i_read_req <= (n == 49);
         @(negedge i_clk);
         n++;
         if (o_read_valid === 1'b1) stray++;
         if (o_busy !== 1'b1 && o_prog_done !== 1'b1) busy_low++;
      end while (o_prog_done !== 1'b1 && n < 130000);
      chk("prog_done", 16'h0001, {15'h0000, o_prog_done});
      chk("busy_gaps", 16'h0000, busy_low[15:0]);
      chk("refused_read", 16'h0000, stray[15:0]);
      chk("model_faults", 16'h0000, faults[15:0]);
      chk("pulse_total", NLOOP * NUM_WORDS, pulses[15:0]);
      for (int a = 0; a < NUM_WORDS; a++)
         chk("cell", (a == 5) ? (img(5) & 8'h0F) : img(a[9:0]),
             u_uvep_dev_model.mem[a]);
      do_read(10'h000, img(10'h000));
      do_read(10'h005, img(10'h005) & 8'h0F);
      do_read(10'h200, img(10'h200));
      do_read(10'h200, img(10'h200));
      do_read(10'h3FF, img(10'h3FF));
      $display("test burn done");
   endtask : test_burn

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude

   // a burn of one pass takes about 11.6 ms
   initial begin
      #14000000;
      miscompares++;
      $display("ERROR watchdog expected finish seen timeout");
      conclude();
   end

   initial begin
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      test_reset();
      test_erased();
      test_burn();
      conclude();
   end
endmodule : tb_uvep_ctrl
